// file: pcre_engine.sv
// Periodic register copy engine with Wishbone command table access
//
// Overview of operation
// - Table holds at most 200 copy commands
// - Each command copies one to 100 registers
// - Source may start anywhere up to status top
// - Destination limited to registers 0 through 3999
// - Code 0 copies data unchanged
// - Code 1 exchanges words of each pair
// - Code 2 exchanges words and their bytes
// - Code 3 exchanges bytes inside each word
// - Per-command repeat preset 0 to 65535 ms
// - Each entry keeps its own interval timer
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "pcre_params.svh"
module pcre_engine (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ms_tick,
    output pcre_pkg::pcre_db_req_t db_o,
    input wire logic db_ack,
    input wire logic [15:0] db_rdata
);
    import pcre_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] bswap(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction

    // Returns {first written, second written}
    function automatic logic [31:0] reorder(input pcre_swap_t code, input logic [15:0] a,
                                            input logic [15:0] b, input logic paired);
        logic [31:0] r;
        r = {a, b};
        unique case (code)
            PCRE_SWAP_NONE: r = {a, b};
            PCRE_SWAP_WORDS: r = paired ? {b, a} : {a, b};
            PCRE_SWAP_BOTH: r = paired ? {bswap(b), bswap(a)} : {bswap(a), b};
            PCRE_SWAP_BYTES: r = {bswap(a), bswap(b)};
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    pcre_state_t st_reg;
    logic en_reg;
    logic ovr_reg;
    logic err_reg;
    logic pend_reg;
    logic [7:0] idx_sw_reg;
    pcre_entry_t stage_reg;
    logic [15:0] copies_reg;
    logic [7:0] idx_reg;
    logic [6:0] off_reg;
    logic [15:0] word_a_reg;
    logic [15:0] second_reg;
    pcre_db_req_t db_reg;
    pcre_entry_t ent;
    logic [`PCRE_ENTRY_W-1:0] ent_raw;
    logic [15:0] tmr_rd;
    logic tmr_we;
    logic [7:0] tmr_wa;
    logic [15:0] tmr_wd;
    logic wb_hit;
    logic wr_hit;
    logic commit_sel;
    logic commit_now;
    logic commit_ok;
    logic start;
    logic [31:0] cur_v;
    logic [31:0] new_v;
    logic [16:0] dst_end;
    logic [16:0] src_end;
    logic fire;
    logic [15:0] tmr_left;
    logic paired;
    logic [31:0] out_pair;
    logic [31:0] out_one;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_hit = wb_hit & wb_we_i;
    assign commit_sel = wb_adr_i == `PCRE_ADR_COMMIT;
    // Table is only touched while no scan runs, so the ack waits for idle
    assign commit_now = wr_hit & commit_sel & (st_reg == PCRE_IDLE);
    assign dst_end = {5'h00, stage_reg.dst} + {10'h000, stage_reg.count} - 17'h00001;
    assign src_end = {1'b0, stage_reg.src} + {10'h000, stage_reg.count} - 17'h00001;
    assign commit_ok = (idx_sw_reg <= `PCRE_LAST_IDX)
        & (stage_reg.count <= `PCRE_MAX_COUNT)
        & ((stage_reg.count == 7'h00) | (dst_end <= {1'b0, `PCRE_DST_TOP}))
        & ((stage_reg.count == 7'h00) | (src_end <= {1'b0, `PCRE_SRC_TOP}));

    always_comb begin
        cur_v = 32'h0000_0000;
        unique case (wb_adr_i)
            `PCRE_ADR_CTRL: cur_v[`PCRE_CTRL_EN_BIT] = en_reg;
            `PCRE_ADR_STATUS: begin
                cur_v[`PCRE_ST_BUSY_BIT] = st_reg != PCRE_IDLE;
                cur_v[`PCRE_ST_OVR_BIT] = ovr_reg;
                cur_v[`PCRE_ST_ERR_BIT] = err_reg;
            end
            `PCRE_ADR_INDEX: cur_v[7:0] = idx_sw_reg;
            `PCRE_ADR_SRC: cur_v[15:0] = stage_reg.src;
            `PCRE_ADR_DST: cur_v[11:0] = stage_reg.dst;
            `PCRE_ADR_CNT: cur_v[9:0] = {stage_reg.swap, 1'b0, stage_reg.count};
            `PCRE_ADR_PRESET: cur_v[15:0] = stage_reg.preset;
            `PCRE_ADR_COPIES: cur_v[15:0] = copies_reg;
            default: cur_v = 32'h0000_0000;
        endcase
    end

    assign new_v = merge(cur_v, wb_dat_i, wb_sel_i);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit & ~(wb_we_i & commit_sel & ~commit_now);
            wb_dat_o <= wb_hit ? cur_v : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_reg <= 1'b0;
            idx_sw_reg <= 8'h00;
            stage_reg <= '0;
        end else if (wr_hit) begin
            unique case (wb_adr_i)
                `PCRE_ADR_CTRL: en_reg <= new_v[`PCRE_CTRL_EN_BIT];
                `PCRE_ADR_INDEX: idx_sw_reg <= new_v[7:0];
                `PCRE_ADR_SRC: stage_reg.src <= new_v[15:0];
                `PCRE_ADR_DST: stage_reg.dst <= new_v[11:0];
                `PCRE_ADR_CNT: begin
                    stage_reg.count <= new_v[6:0];
                    stage_reg.swap <= pcre_swap_t'(new_v[`PCRE_SWAP_LSB +: 2]);
                end
                `PCRE_ADR_PRESET: stage_reg.preset <= new_v[15:0];
                default: ;
            endcase
        end
    end

    // Sticky flags: a new event wins over a same-cycle clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            if (ms_tick & pend_reg) begin
                ovr_reg <= 1'b1;
            end else if (wr_hit & (wb_adr_i == `PCRE_ADR_STATUS) & new_v[`PCRE_ST_OVR_BIT]) begin
                ovr_reg <= 1'b0;
            end
            if (commit_now & ~commit_ok) begin
                err_reg <= 1'b1;
            end else if (wr_hit & (wb_adr_i == `PCRE_ADR_STATUS) & new_v[`PCRE_ST_ERR_BIT]) begin
                err_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command table and per-entry timers
    pcre_table_mem #(.WIDTH(`PCRE_ENTRY_W), .DEPTH(`PCRE_ENTRIES), .AW(`PCRE_IDX_W)) u_cmd (
        .clk(clk),
        .wr_en(commit_now & commit_ok),
        .wr_addr(idx_sw_reg),
        .wr_data(stage_reg),
        .rd_addr(idx_reg),
        .rd_data(ent_raw)
    );

    pcre_table_mem #(.WIDTH(`PCRE_TMR_W), .DEPTH(`PCRE_ENTRIES), .AW(`PCRE_IDX_W)) u_tmr (
        .clk(clk),
        .wr_en(tmr_we),
        .wr_addr(tmr_wa),
        .wr_data(tmr_wd),
        .rd_addr(idx_reg),
        .rd_data(tmr_rd)
    );

    assign ent = pcre_entry_t'(ent_raw);
    // Remaining 0 or 1 means due; preset 0 therefore runs every tick
    assign fire = (ent.count != 7'h00) & (tmr_rd <= 16'h0001);
    assign tmr_left = fire ? ent.preset : (tmr_rd - 16'h0001);
    // A fresh commit zeroes the timer so the entry runs on the next tick
    assign tmr_we = (commit_now & commit_ok) | (st_reg == PCRE_EVAL);
    assign tmr_wa = commit_now ? idx_sw_reg : idx_reg;
    assign tmr_wd = commit_now ? 16'h0000 : tmr_left;

    ////////////////////////////////////////////////////////////////////////////
    // Scan and copy sequencer
    assign start = pend_reg & en_reg & ~commit_now;
    assign paired = ({1'b0, off_reg} + 8'h01) < {1'b0, ent.count};
    assign out_pair = reorder(ent.swap, word_a_reg, db_rdata, paired);
    assign out_one = reorder(ent.swap, db_rdata, 16'h0000, 1'b0);
    assign db_o = db_reg;

    // A tick during a scan is held once; a second one is an overrun
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg <= 1'b0;
        end else if (ms_tick) begin
            pend_reg <= 1'b1;
        end else if (st_reg == PCRE_IDLE && start) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= PCRE_IDLE;
            idx_reg <= 8'h00;
            off_reg <= 7'h00;
            word_a_reg <= 16'h0000;
            second_reg <= 16'h0000;
            db_reg <= '0;
            copies_reg <= 16'h0000;
        end else begin
            unique case (st_reg)
                PCRE_IDLE: begin
                    if (start) begin
                        idx_reg <= 8'h00;
                        st_reg <= PCRE_LOOKUP;
                    end
                end
                PCRE_LOOKUP: st_reg <= PCRE_EVAL;
                PCRE_EVAL: begin
                    off_reg <= 7'h00;
                    if (fire) begin
                        db_reg.we <= 1'b0;
                        db_reg.addr <= ent.src;
                        st_reg <= PCRE_RD_A;
                    end else begin
                        st_reg <= PCRE_NEXT;
                    end
                end
                PCRE_RD_A: begin
                    if (!db_reg.req) begin
                        db_reg.req <= 1'b1;
                    end else if (db_ack) begin
                        db_reg.req <= 1'b0;
                        word_a_reg <= db_rdata;
                        if (paired) begin
                            db_reg.addr <= db_reg.addr + 16'h0001;
                            st_reg <= PCRE_RD_B;
                        end else begin
                            db_reg.we <= 1'b1;
                            db_reg.addr <= {4'h0, ent.dst} + {9'h000, off_reg};
                            db_reg.wdata <= out_one[31:16];
                            st_reg <= PCRE_WR_A;
                        end
                    end
                end
                PCRE_RD_B: begin
                    if (!db_reg.req) begin
                        db_reg.req <= 1'b1;
                    end else if (db_ack) begin
                        db_reg.req <= 1'b0;
                        db_reg.we <= 1'b1;
                        db_reg.addr <= {4'h0, ent.dst} + {9'h000, off_reg};
                        db_reg.wdata <= out_pair[31:16];
                        second_reg <= out_pair[15:0];
                        st_reg <= PCRE_WR_A;
                    end
                end
                PCRE_WR_A: begin
                    if (!db_reg.req) begin
                        db_reg.req <= 1'b1;
                    end else if (db_ack) begin
                        db_reg.req <= 1'b0;
                        if (paired) begin
                            db_reg.addr <= db_reg.addr + 16'h0001;
                            db_reg.wdata <= second_reg;
                            st_reg <= PCRE_WR_B;
                        end else begin
                            db_reg.we <= 1'b0;
                            copies_reg <= copies_reg + 16'h0001;
                            st_reg <= PCRE_NEXT;
                        end
                    end
                end
                PCRE_WR_B: begin
                    if (!db_reg.req) begin
                        db_reg.req <= 1'b1;
                    end else if (db_ack) begin
                        db_reg.req <= 1'b0;
                        db_reg.we <= 1'b0;
                        // Whole copy finishes before the next entry is looked at
                        if (({1'b0, off_reg} + 8'h02) >= {1'b0, ent.count}) begin
                            copies_reg <= copies_reg + 16'h0001;
                            st_reg <= PCRE_NEXT;
                        end else begin
                            off_reg <= off_reg + 7'h02;
                            db_reg.addr <= ent.src + {9'h000, off_reg} + 16'h0002;
                            st_reg <= PCRE_RD_A;
                        end
                    end
                end
                PCRE_NEXT: begin
                    if (idx_reg == `PCRE_LAST_IDX) begin
                        st_reg <= PCRE_IDLE;
                    end else begin
                        idx_reg <= idx_reg + 8'h01;
                        st_reg <= PCRE_LOOKUP;
                    end
                end
            endcase
        end
    end
endmodule

// file: pcre_params.svh
// Constants of the periodic register copy engine
`ifndef PCRE_PARAMS_SVH
`define PCRE_PARAMS_SVH

`define PCRE_ENTRIES 200
`define PCRE_LAST_IDX 8'd199
`define PCRE_IDX_W 8
`define PCRE_ENTRY_W 53
`define PCRE_TMR_W 16
`define PCRE_MAX_COUNT 7'd100
`define PCRE_DST_TOP 16'd3999
`define PCRE_SRC_TOP 16'hffff

`define PCRE_ADR_CTRL 8'h00
`define PCRE_ADR_STATUS 8'h04
`define PCRE_ADR_INDEX 8'h08
`define PCRE_ADR_SRC 8'h0c
`define PCRE_ADR_DST 8'h10
`define PCRE_ADR_CNT 8'h14
`define PCRE_ADR_PRESET 8'h18
`define PCRE_ADR_COMMIT 8'h1c
`define PCRE_ADR_COPIES 8'h20

`define PCRE_CTRL_EN_BIT 0
`define PCRE_ST_BUSY_BIT 0
`define PCRE_ST_OVR_BIT 1
`define PCRE_ST_ERR_BIT 2
`define PCRE_SWAP_LSB 8

`endif

// file: pcre_pkg.sv
// Types of the periodic register copy engine
package pcre_pkg;

    typedef enum logic [1:0] {
        PCRE_SWAP_NONE,
        PCRE_SWAP_WORDS,
        PCRE_SWAP_BOTH,
        PCRE_SWAP_BYTES
    } pcre_swap_t;

    typedef struct packed {
        logic [15:0] src;
        logic [11:0] dst;
        logic [6:0] count;
        pcre_swap_t swap;
        logic [15:0] preset;
    } pcre_entry_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pcre_db_req_t;

    typedef enum logic [2:0] {
        PCRE_IDLE,
        PCRE_LOOKUP,
        PCRE_EVAL,
        PCRE_RD_A,
        PCRE_RD_B,
        PCRE_WR_A,
        PCRE_WR_B,
        PCRE_NEXT
    } pcre_state_t;

endpackage

// file: pcre_table_mem.sv
// Simple one-write one-read memory with registered read data
`timescale 1ns/1ps
module pcre_table_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 200,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // No reset: contents are defined by the commit path before use
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// file: pcre_engine_sva.sv
// Port assertions for the periodic register copy engine
`timescale 1ns/1ps
`include "pcre_params.svh"
module pcre_engine_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ms_tick,
    input wire pcre_pkg::pcre_db_req_t db_o,
    input wire logic db_ack,
    input wire logic [15:0] db_rdata
);
    import pcre_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    ack_cause_a:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    // Commit may wait for the scan, so it is left out here
    ack_prompt_a:
        assert property ($rose(wb_cyc_i && wb_stb_i) && wb_adr_i != `PCRE_ADR_COMMIT
            |=> wb_ack_o) else $error("ack late");
    dat_idle_a:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not zero");
    db_hold_a:
        assert property (db_o.req && !db_ack |=> db_o.req && $stable(db_o))
            else $error("db request changed before ack");
    db_gap_a:
        assert property (db_o.req && db_ack |=> !db_o.req) else $error("db req not dropped");
    db_drop_a:
        assert property ($fell(db_o.req) |-> $past(db_ack)) else $error("db req abandoned");
    dst_top_a:
        assert property (db_o.req && db_o.we |-> db_o.addr <= `PCRE_DST_TOP)
            else $error("write outside user data");
endmodule
bind pcre_engine pcre_engine_sva pcre_engine_sva_i (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ms_tick(ms_tick), .db_o(db_o),
    .db_ack(db_ack), .db_rdata(db_rdata)
);

// file: pcre_db_model.sv
// Register database model answering the engine with random latency
`timescale 1ns/1ps
module pcre_db_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcre_pkg::pcre_db_req_t db_o,
    output logic db_ack,
    output logic [15:0] db_rdata
);
    import pcre_pkg::*;
    logic [15:0] mem [0:65535];
    int seed = 32'h31789101;
    int wait_reg;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'(i) ^ 16'h5a3c;
        end
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            db_ack <= 1'b0;
            db_rdata <= 16'h0;
            wait_reg <= 0;
        end else begin
            // Stale data never stays on the bus
            db_rdata <= ~db_rdata;
            db_ack <= 1'b0;
            if (!db_ack && db_o.req && wait_reg == 0) begin
                db_ack <= 1'b1;
                db_rdata <= mem[db_o.addr];
                if (db_o.we) begin
                    mem[db_o.addr] <= db_o.wdata;
                end
                wait_reg <= $unsigned($random(seed)) % 4;
            end else if (!db_ack && db_o.req) begin
                wait_reg <= wait_reg - 1;
            end
        end
    end
endmodule

// file: periodic_register_copy_engine_test.sv
// Self-checking bench of the copy engine against a queue model
`timescale 1ns/1ps
`include "pcre_params.svh"
module periodic_register_copy_engine_test;
    import pcre_pkg::*;
    typedef struct {logic we; logic [15:0] addr; logic [15:0] data;} pcre_txn_t;
    logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, rdat;
    logic ack, db_ack;
    logic [15:0] db_rdata;
    pcre_db_req_t db_o;
    pcre_txn_t t;
    pcre_txn_t exp_q[$];
    logic [15:0] mdl [0:65535];
    int num_errors = 0, compares = 0, cycles = 0, copies = 0;
    int seed = 32'h31789101;
    int e_src[200], e_dst[200], e_cnt[200], e_swp[200], e_pre[200], e_rem[200];
    pcre_engine pcre_engine_i (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .ms_tick(tick), .db_o(db_o), .db_ack(db_ack), .db_rdata(db_rdata));
    pcre_db_model pcre_db_model_i (.clk(clk), .arst_n(arst_n), .db_o(db_o),
        .db_ack(db_ack), .db_rdata(db_rdata));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic final_report();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic commit(input int i, input int s, input int d, input int c, input int w,
        input int p);
        logic ok;
        ok = i <= 199 && c <= 100 && (c == 0 || (d + c - 1 <= 3999 && s + c - 1 <= 65535));
        wb(1'b1, `PCRE_ADR_INDEX, 32'(i));
        wb(1'b1, `PCRE_ADR_SRC, 32'(s));
        wb(1'b1, `PCRE_ADR_DST, 32'(d));
        wb(1'b1, `PCRE_ADR_CNT, 32'(c + w * 256));
        wb(1'b1, `PCRE_ADR_PRESET, 32'(p));
        wb(1'b1, `PCRE_ADR_COMMIT, 32'h0);
        wb(1'b0, `PCRE_ADR_STATUS, 32'h0);
        check("commit error", 32'(!ok), 32'(rdat[2]));
        if (!ok) begin
            wb(1'b1, `PCRE_ADR_STATUS, 32'h4);
        end else begin
            e_src[i] = s;
            e_dst[i] = d;
            e_cnt[i] = c;
            e_swp[i] = w;
            e_pre[i] = p;
            e_rem[i] = 0;
        end
    endtask
    function automatic logic [15:0] bs(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction
    task automatic put(input logic w, input int a, input logic [15:0] v);
        exp_q.push_back('{w, 16'(a), v});
        if (w) begin
            mdl[16'(a)] = v;
        end
    endtask
    task automatic push_copy(input int e);
        logic [15:0] x, y;
        for (int k = 0; k < e_cnt[e]; k += 2) begin
            x = mdl[16'(e_src[e] + k)];
            put(1'b0, e_src[e] + k, 16'h0);
            if (k + 1 < e_cnt[e]) begin
                y = mdl[16'(e_src[e] + k + 1)];
                put(1'b0, e_src[e] + k + 1, 16'h0);
                case (e_swp[e])
                    1: {x, y} = {y, x};
                    2: {x, y} = {bs(y), bs(x)};
                    3: {x, y} = {bs(x), bs(y)};
                    default: {x, y} = {x, y};
                endcase
                put(1'b1, e_dst[e] + k, x);
                put(1'b1, e_dst[e] + k + 1, y);
            end else begin
                put(1'b1, e_dst[e] + k, e_swp[e] >= 2 ? bs(x) : x);
            end
        end
    endtask
    task automatic model_tick();
        for (int e = 0; e < 200; e++) begin
            if (e_cnt[e] > 0 && e_rem[e] <= 1) begin
                push_copy(e);
                e_rem[e] = e_pre[e];
                copies++;
            end else if (e_cnt[e] > 0) begin
                e_rem[e]--;
            end
        end
    endtask
    task automatic pulse();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask
    // Scan of idle entries costs 3 cycles each after the last copy
    task automatic drain();
        while (exp_q.size() != 0) @(posedge clk);
        repeat (700) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (db_o.req === 1'b1 && db_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("ERROR db request expected none seen %h", db_o.addr);
            end else begin
                t = exp_q.pop_front();
                check("db we", 32'(t.we), 32'(db_o.we));
                check("db addr", 32'(t.addr), 32'(db_o.addr));
                if (t.we) begin
                    check("db wdata", 32'(t.data), 32'(db_o.wdata));
                end
            end
        end
    end
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mdl[i] = 16'(i) ^ 16'h5a3c;
        end
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        // Table memory is not reset, so every entry is cleared first
        for (int i = 0; i < 200; i++) commit(i, 0, 0, 0, 0, 0);
        commit(200, 5, 5, 1, 0, 0);
        commit(5, 0, 3901, 100, 0, 7);
        commit(6, 0, 0, 101, 0, 7);
        commit(0, 100, 10, 3, 0, 0);
        commit(1, 200, 20, 3, 1, 2);
        commit(2, 300, 30, 3, 2, 3);
        commit(3, 400, 40, 3, 3, 1);
        commit(4, 65436, 3900, 100, $unsigned($random(seed)) % 4, 5);
        commit(199, $unsigned($random(seed)) % 60000, 1000, 2, 1, 4);
        wb(1'b0, 8'h24, 32'h0);
        check("unmapped read", 32'h0, rdat);
        wb(1'b1, `PCRE_ADR_CTRL, 32'h1);
        wb(1'b0, `PCRE_ADR_CTRL, 32'h0);
        check("enable", 32'h1, rdat);
        repeat (8) begin
            model_tick();
            pulse();
            // A full scan lasts hundreds of cycles, so busy must show now
            wb(1'b0, `PCRE_ADR_STATUS, 32'h0);
            check("busy status", 32'h1, 32'(rdat[0]));
            drain();
        end
        wb(1'b0, `PCRE_ADR_COPIES, 32'h0);
        check("copies", 32'(copies[15:0]), rdat);
        // Third tick arrives while one is already held
        model_tick();
        model_tick();
        repeat (3) pulse();
        drain();
        wb(1'b0, `PCRE_ADR_STATUS, 32'h0);
        check("overrun status", 32'h2, 32'(rdat[2:0]));
        wb(1'b1, `PCRE_ADR_STATUS, 32'h2);
        wb(1'b0, `PCRE_ADR_STATUS, 32'h0);
        check("cleared status", 32'h0, 32'(rdat[2:0]));
        final_report();
    end
endmodule
